//--- hdl/cmf_consts.svh
`ifndef CMF_CONSTS_SVH
`define CMF_CONSTS_SVH
// Contract
// - bit rate is clock over 2 times divider, prescaler and quanta per bit
// - module clock divider selectable as 1, 2, 4, 8 or 16
// - prescaler divides by four-bit field plus one
// - global mask for slots 0-13, mask A slot 14, mask B slot 15
// - mask covers 11 or 29 id bits per extended-select bit
// - identical identifier in two slots: lower slot alone valid
// - accept-all slots 14/15 in dual mode take frames unclaimed by 0-13
// - helper holds received standard id and decodes it for table search
// - dual mode lets slots 14/15 take data and remote frames
// - dual mode stores successive frames alternately in slots 14 and 15
// - dual mode remote indicator shows type of frame received
// - dual mode slots have no overwrite protection
// - forced return from bus-off: error active, counters and flag cleared
// - resume after 11 recessive bits if forced, else after 128 such runs
// - free-running time stamp ticks per bit time divided by 1, 2, 4, 8
// - successful reception stores time stamp into receiving slot
// - listen-only drives nothing onto the bus
// - slot request bits decode to configure, receive data, transmit data
// - remote-send slot becomes data receiver after sending or early match
// - remote-receive slot becomes data transmitter, held while response locked
// - frame goes to first slot matching mode and filter, lowest first, except slot 15 over 14 on alternate turns in dual mode
// - own frame received only in loop-back, never acknowledged
`define CMF_A_CTL 12'h000
`define CMF_A_CLK 12'h004
`define CMF_A_CONF 12'h008
`define CMF_A_GMASK 12'h00c
`define CMF_A_LMA 12'h010
`define CMF_A_LMB 12'h014
`define CMF_A_EXT 12'h018
`define CMF_A_FLT 12'h01c
`define CMF_A_STAT 12'h020
`define CMF_A_TS 12'h024
`define CMF_SLOT_PAGE 4'h1
`define CMF_W_CTL 2'h0
`define CMF_W_ID 2'h1
`define CMF_W_TS 2'h2
`define CMF_CTL_BASIC 0
`define CMF_CTL_LO 1
`define CMF_CTL_LB 2
`define CMF_CTL_FR 5
`define CMF_CTL_TSR 6
`define CMF_CONF_RST 9'h0a0
`define CMF_BASE_DIV 2
`define CMF_MAX_SEL 3'h4
`define CMF_SEQ_BITS 11
`define CMF_OCC_CNT 128
`define CMF_SLOT_A 14
`define CMF_SLOT_B 15
`define CMF_MSK_STD 29'h00007ff
`define CMF_MSK_EXT 29'h1fffffff
`endif

//--- hdl/cmf_pkg.sv
package cmf_pkg;
  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic rtr;
    logic own;
  } cmf_frame_t;
  typedef struct packed {
    logic tx_req;
    logic rx_req;
    logic remote;
    logic rsp_lock;
    logic rem_ind;
    logic sending;
    logic new_data;
  } cmf_sctl_t;
  typedef enum logic [1:0] {
    CMF_ACTIVE = 2'b00,
    CMF_BUSOFF = 2'b01,
    CMF_WAIT = 2'b10
  } cmf_err_t;
endpackage : cmf_pkg

//--- hdl/cmf_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmf_consts.svh"
module cmf_top #(
  parameter int NS = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol core
  input wire cmf_pkg::cmf_frame_t rx_frame,
  input wire logic rx_done,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_lost,
  input wire logic busoff_enter,
  input wire logic [7:0] core_tec,
  input wire logic [7:0] core_rec,
  input wire logic core_tx,
  output logic tx_valid,
  output logic [3:0] tx_slot,
  output logic ack_en,
  output logic bit_tick,
  output logic bus_ready,
  output logic err_clr,
  // bus pins
  input wire logic can_rx,
  output logic can_tx
);
  import cmf_pkg::*;

  logic [4:0] ctl_r;
  logic [2:0] clk_r;
  logic [8:0] conf_r;
  logic [28:0] gmask_r, lma_r, lmb_r;
  logic [15:0] ext_r;
  logic [10:0] flt_r;
  logic [7:0] tec_r, rec_r;
  logic [15:0] ts_r;
  logic [2:0] ts_pre_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  cmf_sctl_t sctl_r [NS];
  logic [28:0] sid_r [NS];
  logic [15:0] sts_r [NS];
  logic basic, lo, lb;
  logic wr_go, sw_slot, fr_wr, tsr_wr, fr_go;
  logic [3:0] wsi;
  logic [1:0] wsw;
  assign basic = ctl_r[`CMF_CTL_BASIC];
  assign lo = ctl_r[`CMF_CTL_LO];
  assign lb = ctl_r[`CMF_CTL_LB];

  // zero wait states: read data is latched in the setup cycle, write data in the access cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign wr_go = psel & penable & pwrite;
  assign sw_slot = wr_go && (paddr[11:8] == `CMF_SLOT_PAGE) && (paddr[1:0] == 2'h0);
  assign wsi = paddr[7:4];
  assign wsw = paddr[3:2];
  assign fr_wr = wr_go && (paddr == `CMF_A_CTL) && pwdata[`CMF_CTL_FR];
  assign tsr_wr = wr_go && (paddr == `CMF_A_CTL) && pwdata[`CMF_CTL_TSR];

  function automatic logic [9:0] cmf_tq_len(input logic [2:0] sel, input logic [3:0] baud_prescaler_field);
    logic [4:0] dv;
    dv = (sel > `CMF_MAX_SEL) ? 5'h10 : 5'(5'h1 << sel);
    return 10'(`CMF_BASE_DIV * dv * ({1'b0, baud_prescaler_field} + 5'h1));
  endfunction : cmf_tq_len

  function automatic logic cmf_idmatch(input logic [28:0] rid, input logic [28:0] sid,
                                       input logic [28:0] msk, input logic ext);
    logic [28:0] w;
    w = ext ? `CMF_MSK_EXT : `CMF_MSK_STD;
    return ((rid ^ sid) & msk & w) == 29'h0;
  endfunction : cmf_idmatch

  // row in bits 23:16, one-hot column in 31:24
  function automatic logic [31:0] cmf_flt_dec(input logic [10:0] id);
    return {8'(8'h1 << id[2:0]), id[10:3], 5'h0, id};
  endfunction : cmf_flt_dec

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 5'h0;
      clk_r <= 3'h0;
      conf_r <= `CMF_CONF_RST;
      gmask_r <= 29'h0;
      lma_r <= 29'h0;
      lmb_r <= 29'h0;
      ext_r <= 16'h0;
    end else if (wr_go) begin
      if (paddr == `CMF_A_CTL) begin
        ctl_r <= pwdata[4:0];
      end else if (paddr == `CMF_A_CLK) begin
        clk_r <= pwdata[2:0];
      end else if (paddr == `CMF_A_CONF) begin
        conf_r <= pwdata[8:0];
      end else if (paddr == `CMF_A_GMASK) begin
        gmask_r <= pwdata[28:0];
      end else if (paddr == `CMF_A_LMA) begin
        lma_r <= pwdata[28:0];
      end else if (paddr == `CMF_A_LMB) begin
        lmb_r <= pwdata[28:0];
      end else if (paddr == `CMF_A_EXT) begin
        ext_r <= pwdata[15:0];
      end
    end
  end

  // bit timing
  logic [9:0] tq_cnt_r, tq_len;
  logic [4:0] tq_bit_r, tqb;
  logic tq_tick, bt;
  assign tq_len = cmf_tq_len(clk_r, conf_r[3:0]);
  assign tqb = (conf_r[8:4] == 5'h0) ? 5'h1 : conf_r[8:4];
  assign tq_tick = (tq_cnt_r >= tq_len - 10'h1);
  assign bt = tq_tick && (tq_bit_r >= tqb - 5'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_cnt_r <= 10'h0;
      tq_bit_r <= 5'h0;
      bit_tick <= 1'b0;
    end else begin
      tq_cnt_r <= tq_tick ? 10'h0 : tq_cnt_r + 10'h1;
      if (tq_tick) begin
        tq_bit_r <= bt ? 5'h0 : tq_bit_r + 5'h1;
      end
      bit_tick <= bt;
    end
  end

  // bus level sync and recessive run detection
  logic rx_s1_r, rx_s2_r, seq11;
  logic [3:0] run_r;
  assign seq11 = bt && rx_s2_r && (run_r == 4'(`CMF_SEQ_BITS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= can_rx;
      rx_s2_r <= rx_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 4'h0;
    end else if (bt) begin
      run_r <= (!rx_s2_r || seq11) ? 4'h0 : run_r + 4'h1;
    end
  end

  // fault confinement exit
  cmf_err_t err_st_r;
  logic [6:0] occ_r;
  assign fr_go = fr_wr && (err_st_r == CMF_BUSOFF);
  assign bus_ready = (err_st_r == CMF_ACTIVE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_st_r <= CMF_ACTIVE;
      occ_r <= 7'h0;
    end else begin
      case (err_st_r)
        CMF_ACTIVE: begin
          if (busoff_enter) begin
            err_st_r <= CMF_BUSOFF;
            occ_r <= 7'h0;
          end
        end
        CMF_BUSOFF: begin
          if (fr_go) begin
            err_st_r <= CMF_WAIT;
          end else if (seq11) begin
            if (occ_r == 7'(`CMF_OCC_CNT - 1)) begin
              err_st_r <= CMF_ACTIVE;
            end
            occ_r <= occ_r + 7'h1;
          end
        end
        CMF_WAIT: begin
          if (seq11) begin
            err_st_r <= CMF_ACTIVE;
          end
        end
        default: err_st_r <= CMF_ACTIVE;
      endcase
    end
  end

  // core keeps its own counters; err_clr tells it to zero them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tec_r <= 8'h0;
      rec_r <= 8'h0;
      err_clr <= 1'b0;
    end else begin
      // core zeroes one cycle late, so hold zero while err_clr is out
      tec_r <= (fr_go || err_clr) ? 8'h0 : core_tec;
      rec_r <= (fr_go || err_clr) ? 8'h0 : core_rec;
      err_clr <= fr_go;
    end
  end

  // time stamp
  logic [2:0] tsp_lim;
  assign tsp_lim = 3'((4'h1 << ctl_r[4:3]) - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_r <= 16'h0;
      ts_pre_r <= 3'h0;
    end else if (tsr_wr) begin
      ts_r <= 16'h0;
      ts_pre_r <= 3'h0;
    end else if (bt) begin
      if (ts_pre_r >= tsp_lim) begin
        ts_pre_r <= 3'h0;
        ts_r <= ts_r + 16'h1;
      end else begin
        ts_pre_r <= ts_pre_r + 3'h1;
      end
    end
  end

  // acceptance and transmit choice
  logic [NS-1:0] acc, elig, snd;
  logic [3:0] hit_j, cur_tx_r;
  logic hit_any, take, st_go, alt_r;

  always_comb begin
    cmf_sctl_t c;
    logic [28:0] msk;
    logic tok;
    c = '0;
    msk = 29'h0;
    tok = 1'b0;
    acc = '0;
    elig = '0;
    snd = '0;
    for (int j = 0; j < NS; j++) begin
      c = sctl_r[j];
      msk = (j == `CMF_SLOT_A) ? lma_r : (j == `CMF_SLOT_B) ? lmb_r : gmask_r;
      if (basic && j >= `CMF_SLOT_A) begin
        tok = !c.tx_req && c.rx_req;
      end else begin
        tok = (!c.tx_req && c.rx_req && (c.remote == rx_frame.rtr))
            || (c.tx_req && !c.rx_req && c.remote && !c.sending && !rx_frame.rtr);
      end
      acc[j] = tok && (rx_frame.ext == ext_r[j]) && cmf_idmatch(rx_frame.id, sid_r[j], msk,
                                                               rx_frame.ext);
      elig[j] = c.tx_req && !c.rx_req && !c.rsp_lock && !c.sending;
      snd[j] = c.sending;
    end
  end

  always_comb begin
    hit_j = 4'h0;
    hit_any = 1'b0;
    tx_slot = 4'h0;
    for (int j = NS - 1; j >= 0; j--) begin
      if (acc[j]) begin
        hit_j = 4'(j);
        hit_any = 1'b1;
      end
      if (elig[j]) begin
        tx_slot = 4'(j);
      end
    end
    if (basic && acc[`CMF_SLOT_A] && acc[`CMF_SLOT_B] && hit_j == 4'(`CMF_SLOT_A) && alt_r) begin
      hit_j = 4'(`CMF_SLOT_B);
    end
  end

  assign take = rx_done && (!rx_frame.own || lb);
  assign st_go = take && hit_any;
  assign tx_valid = (|elig) && !(|snd) && !lo && bus_ready;
  assign ack_en = !lo && !rx_frame.own;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r <= 1'b0;
      cur_tx_r <= 4'h0;
      can_tx <= 1'b1;
    end else begin
      if (st_go && basic && hit_j >= 4'(`CMF_SLOT_A)) begin
        alt_r <= (hit_j == 4'(`CMF_SLOT_A));
      end
      if (tx_start) begin
        cur_tx_r <= tx_slot;
      end
      can_tx <= lo ? 1'b1 : core_tx;
    end
  end

  // helper wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_r <= 11'h0;
    end else if (rx_done && !rx_frame.ext) begin
      flt_r <= rx_frame.id[10:0];
    end else if (wr_go && paddr == `CMF_A_FLT) begin
      flt_r <= pwdata[10:0];
    end
  end

  // slots: hardware events follow the software write so they win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int j = 0; j < NS; j++) begin
        sctl_r[j] <= '0;
        sid_r[j] <= 29'h0;
        sts_r[j] <= 16'h0;
      end
    end else begin
      for (int j = 0; j < NS; j++) begin
        if (sw_slot && wsi == 4'(j)) begin
          if (wsw == `CMF_W_CTL) begin
            sctl_r[j] <= {pwdata[6:3], (pwdata[6] | pwdata[5]) & pwdata[4],
                          sctl_r[j].sending, pwdata[0]};
          end else if (wsw == `CMF_W_ID) begin
            sid_r[j] <= pwdata[28:0];
          end
        end
        if (st_go && hit_j == 4'(j)) begin
          sctl_r[j].new_data <= 1'b1;
          sts_r[j] <= ts_r;
          if (basic && j >= `CMF_SLOT_A) begin
            sctl_r[j].rem_ind <= rx_frame.rtr;
          end else if (sctl_r[j].tx_req) begin
            sctl_r[j].tx_req <= 1'b0;
            sctl_r[j].rx_req <= 1'b1;
            sctl_r[j].remote <= 1'b0;
            sctl_r[j].rem_ind <= 1'b0;
          end else if (sctl_r[j].remote) begin
            sctl_r[j].tx_req <= 1'b1;
            sctl_r[j].rx_req <= 1'b0;
            sctl_r[j].remote <= 1'b0;
            sctl_r[j].rem_ind <= 1'b0;
          end
        end
        if (tx_start && tx_slot == 4'(j)) begin
          sctl_r[j].sending <= 1'b1;
        end else if ((tx_done || tx_lost) && cur_tx_r == 4'(j)) begin
          sctl_r[j].sending <= 1'b0;
          if (tx_done && sctl_r[j].remote) begin
            sctl_r[j].tx_req <= 1'b0;
            sctl_r[j].rx_req <= 1'b1;
            sctl_r[j].remote <= 1'b0;
            sctl_r[j].rem_ind <= 1'b0;
          end
        end
      end
    end
  end

  // read mux, sampled in the setup cycle
  logic [31:0] rd_c;
  logic err_c;
  always_comb begin
    rd_c = 32'h0;
    err_c = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      err_c = 1'b1;
    end else if (paddr[11:8] == `CMF_SLOT_PAGE) begin
      if (wsw == `CMF_W_CTL) begin
        rd_c = {25'h0, sctl_r[wsi]};
      end else if (wsw == `CMF_W_ID) begin
        rd_c = {3'h0, sid_r[wsi]};
      end else if (wsw == `CMF_W_TS) begin
        rd_c = {16'h0, sts_r[wsi]};
      end else begin
        err_c = 1'b1;
      end
    end else if (paddr == `CMF_A_CTL) begin
      rd_c = {27'h0, ctl_r};
    end else if (paddr == `CMF_A_CLK) begin
      rd_c = {29'h0, clk_r};
    end else if (paddr == `CMF_A_CONF) begin
      rd_c = {23'h0, conf_r};
    end else if (paddr == `CMF_A_GMASK) begin
      rd_c = {3'h0, gmask_r};
    end else if (paddr == `CMF_A_LMA) begin
      rd_c = {3'h0, lma_r};
    end else if (paddr == `CMF_A_LMB) begin
      rd_c = {3'h0, lmb_r};
    end else if (paddr == `CMF_A_EXT) begin
      rd_c = {16'h0, ext_r};
    end else if (paddr == `CMF_A_FLT) begin
      rd_c = cmf_flt_dec(flt_r);
    end else if (paddr == `CMF_A_STAT) begin
      rd_c = {8'h0, tec_r, rec_r, 6'h0, bus_ready, err_st_r == CMF_BUSOFF};
    end else if (paddr == `CMF_A_TS) begin
      rd_c = {16'h0, ts_r};
    end else begin
      err_c = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0 : rd_c;
      pslverr_r <= err_c;
    end
  end

  property p_lo_quiet;
    @(posedge pclk) disable iff (!presetn) lo |=> can_tx;
  endproperty
  a_lo_quiet: assert property (p_lo_quiet) else $error("bus driven in listen-only");

  property p_lo_notx;
    @(posedge pclk) disable iff (!presetn) lo |-> !tx_valid && !ack_en;
  endproperty
  a_lo_notx: assert property (p_lo_notx) else $error("request in listen-only");

  property p_own_noack;
    @(posedge pclk) disable iff (!presetn) rx_frame.own |-> !ack_en;
  endproperty
  a_own_noack: assert property (p_own_noack) else $error("ack for own frame");

  property p_fr_clear;
    @(posedge pclk) disable iff (!presetn)
      fr_go |=> (err_st_r == CMF_WAIT && tec_r == 8'h0 && rec_r == 8'h0 && err_clr)
      ##1 (tec_r == 8'h0 && rec_r == 8'h0);
  endproperty
  a_fr_clear: assert property (p_fr_clear) else $error("forced return incomplete");

  property p_fr_wait;
    @(posedge pclk) disable iff (!presetn)
      err_st_r == CMF_WAIT && !seq11 |=> !bus_ready;
  endproperty
  a_fr_wait: assert property (p_fr_wait) else $error("ready before recessive run");

  property p_ts_cap;
    @(posedge pclk) disable iff (!presetn)
      st_go && !(sw_slot && wsi == hit_j) |=> sts_r[$past(hit_j)] == $past(ts_r);
  endproperty
  a_ts_cap: assert property (p_ts_cap) else $error("time stamp not captured");

  property p_prio;
    @(posedge pclk) disable iff (!presetn)
      st_go && !basic |-> acc[hit_j] && ((acc & ((16'h1 << hit_j) - 16'h1)) == 16'h0);
  endproperty
  a_prio: assert property (p_prio) else $error("not the lowest matching slot");

  property p_alt;
    @(posedge pclk) disable iff (!presetn)
      st_go && basic && acc[`CMF_SLOT_A] && acc[`CMF_SLOT_B] && alt_r
      |-> hit_j == 4'(`CMF_SLOT_B) ##1 !alt_r;
  endproperty
  a_alt: assert property (p_alt) else $error("dual slots not alternating");

  c_basic_b: cover property (@(posedge pclk) st_go && basic && hit_j == 4'(`CMF_SLOT_B));
  c_force: cover property (@(posedge pclk) fr_go ##[1:1000] bus_ready);
  c_tx: cover property (@(posedge pclk) tx_valid && tx_start);
endmodule : cmf_top
`default_nettype wire

//--- sim/cmf_core_mdl.sv
`timescale 1ns/1ns
`default_nettype none
module cmf_core_mdl (
  // clock
  input wire logic pclk,
  // towards the block
  output cmf_pkg::cmf_frame_t rx_frame,
  output logic rx_done,
  output logic tx_start,
  output logic tx_done,
  output logic tx_lost,
  output logic busoff_enter,
  output logic [7:0] core_tec,
  output logic [7:0] core_rec,
  output logic core_tx,
  output logic can_rx,
  // from the block
  input wire logic err_clr
);
  import cmf_pkg::*;
  initial begin
    rx_frame = '0;
    {tx_lost, tx_start, tx_done, busoff_enter, rx_done} = 5'h00;
    core_tec = 8'h00;
    core_rec = 8'h00;
    core_tx = 1'h1;
    can_rx = 1'h1;
  end
  // the core zeroes its own counters when told to
  always @(posedge pclk) begin
    if (err_clr) begin
      core_tec <= 8'h00;
      core_rec <= 8'h00;
    end
  end
  task automatic frame(input logic [28:0] id, input logic ext, rtr, own);
    rx_frame <= '{id, ext, rtr, own};
    @(posedge pclk);
  endtask : frame
  // v = {tx_lost, tx_start, tx_done, busoff_enter, rx_done}
  task automatic strobe(input logic [4:0] v);
    {tx_lost, tx_start, tx_done, busoff_enter, rx_done} <= v;
    @(posedge pclk);
    {tx_lost, tx_start, tx_done, busoff_enter, rx_done} <= 5'h00;
    // stale frame must not look valid, so scramble it
    if (v[0])
      rx_frame <= ~rx_frame;
    @(posedge pclk);
  endtask : strobe
endmodule : cmf_core_mdl
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import cmf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic tx_valid, ack_en, bit_tick, bus_ready, err_clr, can_tx, core_tx, can_rx;
  logic rx_done, tx_start, tx_done, tx_lost, busoff_enter;
  logic [3:0] tx_slot;
  logic [7:0] core_tec, core_rec;
  cmf_frame_t rx_frame;
  int bad_count, num_checks, cyc, n, lo, hi;
  int sl[5] = '{0, 1, 2, 14, 15};
  cmf_top cmf_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_frame, .rx_done, .tx_start, .tx_done, .tx_lost, .busoff_enter,
    .core_tec, .core_rec, .core_tx, .tx_valid, .tx_slot, .ack_en, .bit_tick, .bus_ready,
    .err_clr, .can_rx, .can_tx);
  cmf_core_mdl cmf_core_mdl_i (.pclk, .rx_frame, .rx_done, .tx_start, .tx_done, .tx_lost,
    .busoff_enter, .core_tec, .core_rec, .core_tx, .can_rx, .err_clr);
  initial pclk = 1'h0;
  always #50 pclk = ~pclk;
  task automatic print_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] m, e);
    xfer(1'h0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, q & m)
  endtask : rc
  function automatic logic [11:0] sa(input int j, w);
    return 12'h100 + 12'(j * 16 + w * 4);
  endfunction : sa
  task automatic cfg(input int j, input logic [28:0] id, input logic [31:0] c);
    wr(sa(j, 0), 32'h0);
    wr(sa(j, 1), 32'(id));
    wr(sa(j, 0), c);
  endtask : cfg
  task automatic ticks(input int k);
    repeat (k) begin
      do @(posedge pclk); while (bit_tick !== 1'h1);
    end
  endtask : ticks
  task automatic per(output int c);
    c = 0;
    ticks(1);
    do begin
      @(posedge pclk);
      c++;
    end while (bit_tick !== 1'h1);
  endtask : per
  task automatic stb(input logic [4:0] v);
    cmf_core_mdl_i.strobe(v);
  endtask : stb
  task automatic rx(input logic [28:0] id, input logic [2:0] f);
    cmf_core_mdl_i.frame(id, f[2], f[1], f[0]);
    stb(5'h01);
  endtask : rx
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rc(12'h008, 32'hffffffff, 32'h0a0);
    rc(12'h020, 32'h00ffff03, 32'h2);
    xfer(1'h0, 12'h030, 32'h0);
    `CHK("unmapped", 1'h1, err)
    for (int i = 0; i < 6; i++) begin
      lo = (i == 5) ? 15 : i * 3;
      hi = (i == 5) ? 7 : i;
      wr(12'h004, 32'(hi));
      wr(12'h008, 32'(lo) | 32'h20);
      per(n);
      per(n);
      `CHK("bit period", 4 * ((hi > 4) ? 16 : (1 << hi)) * (lo + 1), n)
    end
    // shortest legal bit: four clocks, keeps the long recovery test cheap
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h20);
    for (int k = 0; k < 4; k++) begin
      wr(12'h000, 32'h40 | 32'(k << 3));
      ticks(16);
      xfer(1'h0, 12'h024, 32'h0);
      n = 16 >> k;
      `CHK("ts count", 1'h1, q[15:0] >= 16'(n - 1) && q[15:0] <= 16'(n + 1))
    end
    wr(12'h000, 32'h0);
    wr(12'h018, 32'h2);
    wr(12'h00c, 32'h1ffffff0);
    wr(12'h010, 32'h7ff);
    wr(12'h014, 32'h0);
    foreach (sl[i])
      cfg(sl[i], (sl[i] < 3) ? 29'h120 : 29'h0, 32'h20);
    rx(29'h1ffff925, 3'h0);
    rc(sa(0, 0), 32'h7f, 32'h21);
    rc(sa(2, 0), 32'h7f, 32'h20);
    rc(12'h01c, 32'hffffffff, 32'h20240125);
    wr(sa(0, 0), 32'h20);
    rx(29'h10000121, 3'h4);
    rc(sa(1, 0), 32'h7f, 32'h20);
    rx(29'h127, 3'h4);
    rc(sa(0, 0), 32'h7f, 32'h20);
    rc(sa(1, 0), 32'h7f, 32'h21);
    rc(12'h01c, 32'h7ff, 32'h125);
    rx(29'h135, 3'h0);
    rc(sa(15, 0), 32'h7f, 32'h21);
    wr(sa(15, 0), 32'h20);
    rx(29'h005, 3'h0);
    rc(sa(14, 0), 32'h7f, 32'h20);
    rc(sa(15, 0), 32'h7f, 32'h21);
    xfer(1'h0, 12'h024, 32'h0);
    lo = q[15:0];
    rx(29'h000, 3'h0);
    rc(sa(14, 0), 32'h7f, 32'h21);
    xfer(1'h0, sa(14, 2), 32'h0);
    n = q[15:0];
    xfer(1'h0, 12'h024, 32'h0);
    `CHK("rx stamp", 1'h1, n >= lo && n <= q[15:0] && n != 0)
    cfg(0, 29'h310, 32'h20);
    cfg(1, 29'h0, 32'h0);
    cfg(2, 29'h0, 32'h0);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rx(29'h300 + 29'(i), {1'h0, 1'(i == 1 || i == 2), 1'h0});
      rc(sa(14 + i % 2, 0), 32'h7f, (i == 1 || i == 2) ? 32'h25 : 32'h21);
    end
    rx(29'h310, 3'h0);
    rc(sa(0, 0), 32'h7f, 32'h21);
    rc(sa(14, 0), 32'h7f, 32'h25);
    wr(12'h000, 32'h0);
    foreach (sl[i])
      wr(sa(sl[i], 0), 32'h0);
    cfg(3, 29'h033, 32'h40);
    `CHK("tx_valid", 1'h1, tx_valid)
    `CHK("tx_slot", 4'h3, tx_slot)
    stb(5'h08);
    rc(sa(3, 0), 32'h7f, 32'h42);
    stb(5'h04);
    rc(sa(3, 0), 32'h7f, 32'h40);
    wr(sa(3, 0), 32'h0);
    cfg(4, 29'h044, 32'h50);
    rc(sa(4, 0), 32'h7f, 32'h54);
    `CHK("tx_slot", 4'h4, tx_slot)
    stb(5'h08);
    stb(5'h04);
    rc(sa(4, 0), 32'h7c, 32'h20);
    cfg(5, 29'h055, 32'h50);
    rx(29'h055, 3'h0);
    rc(sa(5, 0), 32'h7d, 32'h21);
    `CHK("tx_valid", 1'h0, tx_valid)
    cfg(6, 29'h066, 32'h38);
    rx(29'h066, 3'h2);
    rc(sa(6, 0), 32'h7c, 32'h48);
    `CHK("tx_valid", 1'h0, tx_valid)
    wr(sa(6, 0), 32'h40);
    `CHK("tx_slot", 4'h6, tx_slot)
    stb(5'h08);
    stb(5'h10);
    `CHK("tx_valid", 1'h1, tx_valid)
    wr(sa(6, 0), 32'h0);
    cfg(7, 29'h077, 32'h20);
    for (int b = 0; b < 2; b++) begin
      wr(12'h000, 32'(b << 2));
      cmf_core_mdl_i.frame(29'h077, 1'h0, 1'h0, 1'h1);
      `CHK("ack_en", 1'h0, ack_en)
      stb(5'h01);
      rc(sa(7, 0), 32'h7f, 32'h20 | 32'(b));
    end
    wr(12'h000, 32'h2);
    cfg(8, 29'h088, 32'h40);
    cmf_core_mdl_i.core_tx <= 1'h0;
    cmf_core_mdl_i.frame(29'h123, 1'h0, 1'h0, 1'h0);
    @(posedge pclk);
    `CHK("tx_valid", 1'h0, tx_valid)
    `CHK("can_tx", 1'h1, can_tx)
    `CHK("ack_en", 1'h0, ack_en)
    wr(12'h000, 32'h0);
    // can_tx is registered: it follows lo one edge later
    @(posedge pclk);
    `CHK("can_tx", 1'h0, can_tx)
    `CHK("tx_valid", 1'h1, tx_valid)
    cmf_core_mdl_i.core_tx <= 1'h1;
    wr(sa(8, 0), 32'h0);
    cmf_core_mdl_i.core_tec <= 8'h80;
    cmf_core_mdl_i.core_rec <= 8'h11;
    stb(5'h02);
    rc(12'h020, 32'h00ffff03, 32'h00801101);
    wr(12'h000, 32'h20);
    ticks(1);
    rc(12'h020, 32'h00ffff03, 32'h0);
    rc(12'h008, 32'hffffffff, 32'h20);
    rc(sa(7, 1), 32'h1fffffff, 32'h077);
    // dominant bus must hold off recovery however long it lasts
    cmf_core_mdl_i.can_rx <= 1'h0;
    ticks(40);
    `CHK("bus_ready", 1'h0, bus_ready)
    cmf_core_mdl_i.can_rx <= 1'h1;
    ticks(9);
    `CHK("bus_ready", 1'h0, bus_ready)
    ticks(4);
    `CHK("bus_ready", 1'h1, bus_ready)
    stb(5'h02);
    ticks(1396);
    `CHK("bus_ready", 1'h0, bus_ready)
    ticks(24);
    `CHK("bus_ready", 1'h1, bus_ready)
    print_verdict();
  end
endmodule : tb
`default_nettype wire
